// ==== design/ucr_common_regs.v ====
// Function
// - 7-bit address, write sets pending bit 7
// - Iso hold sends zero-length until frame start
// - Bus reset status readable at bit 3
// - Wakeup bit drives resume signaling
// - Suspended status; cleared by read or wakeup
// - Suspend after 3 ms idle when allowed
// - IN and control endpoint flags, clear on read
// - OUT endpoint flags bits 5:1, clear on read
// - Frame start flag bit 3, clear on read
// - Reset, resume, suspend flags, clear on read
// - IN endpoint enables reset to one
// - OUT endpoint enables bits 5:1, reset one
// - Bus reset zeroes address, restores all but frame start and suspend enables
// - Enabled flag raises shared interrupt line
// - Decode registers in the data space window
`timescale 1ns/100ps
`include "ucr_regs.vh"

module ucr_common_regs #(
  parameter integer SUSPEND_IDLE_CYCLES = `UCR_SUSP_IDLE_MS * `UCR_CYC_PER_MS,
  parameter integer CNT_W               = 20
) (
  // Clock, reset and clock enable
  input  wire        clk,
  input  wire        resetn,
  input  wire        ce,
  // Register access from the processor data space
  input  wire [15:0] xAddr,
  input  wire [7:0]  xWrData,
  input  wire        xWrEn,
  input  wire        xRdEn,
  output reg  [7:0]  xRdData,
  // Status from the packet engine
  input  wire        addrApplied,
  input  wire        inPacketLoaded,
  input  wire        inEndpointIsIso,
  // Bus line state seen by the transceiver
  input  wire        frameStart,
  input  wire        busResetActive,
  input  wire        busIdle,
  // Per-endpoint transfer events
  input  wire [5:0]  inEndpointEvent,
  input  wire [5:1]  outEndpointEvent,
  // Controls toward the packet engine and the bus
  output reg  [6:0]  functionAddress,
  output reg         isoZeroLenHold,
  output reg         resumeDrive,
  output reg         suspendMode,
  output reg         endpointStateClear,
  // Shared interrupt toward the processor
  output reg         controllerIrq
);

  // Cut to the counter width on purpose; CNT_W must hold the count
  localparam integer     IDLE_LAST_I = SUSPEND_IDLE_CYCLES - 1;
  localparam [CNT_W-1:0] IDLE_LAST   = IDLE_LAST_I[CNT_W-1:0];

  // Exact address match, used by every register strobe
  function hit;
    input [15:0] a;
    input [15:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // Flag update with hardware set winning over read clear
  function [5:0] upd;
    input [5:0] cur;
    input [5:0] set;
    input       clr;
    begin
      upd = (clr ? 6'h00 : cur) | set;
    end
  endfunction

  // Stored register fields and flags
  reg             addrPending;
  reg             isoHoldEn;
  reg             suspendAllow;
  reg [5:0]       inFlags;
  reg [5:1]       outFlags;
  reg [3:0]       comFlags;
  reg [7:0]       inEnables;
  reg [7:0]       outEnables;
  reg [3:0]       comEnables;
  // Idle timer and edge history of the bus levels
  reg [CNT_W-1:0] idleCount;
  reg             idleSpent;
  reg             busResetSeen;
  reg             busIdleSeen;

  // Next values from the combinational blocks
  reg [7:0]       next_rdData;
  reg [5:0]       next_inFlags;
  reg [5:0]       next_outFlags;
  reg [3:0]       next_comFlags;
  reg             next_suspendMode;
  reg             next_irq;

  // Window decode; an access outside the window touches nothing
  wire inWin = (xAddr >= `UCR_WIN_BASE) && (xAddr <= `UCR_WIN_LAST);
  wire rd    = xRdEn & inWin;
  wire wr    = xWrEn & inWin;

  // One strobe per register; a read strobes only the clear-on-read flags
  wire wrAddr  = wr & hit(xAddr, `UCR_OFS_ADDR);
  wire wrPower = wr & hit(xAddr, `UCR_OFS_POWER);
  wire wrInEn  = wr & hit(xAddr, `UCR_OFS_INEN);
  wire wrOutEn = wr & hit(xAddr, `UCR_OFS_OUTEN);
  wire wrComEn = wr & hit(xAddr, `UCR_OFS_COMEN);
  wire rdInF   = rd & hit(xAddr, `UCR_OFS_INFLAG);
  wire rdOutF  = rd & hit(xAddr, `UCR_OFS_OUTFLAG);
  wire rdComF  = rd & hit(xAddr, `UCR_OFS_COMFLAG);

  // Bus reset is acted on once, at its leading edge
  wire busResetRise = busResetActive & ~busResetSeen;
  // Leaving idle while suspended is a resume, unless it is a reset
  wire resumeEvent  = suspendMode & busIdleSeen & ~busIdle & ~busResetActive;
  // Suspend entry: idle counter expires while allowed
  wire suspendEnter = suspendAllow & busIdle & ~idleSpent &
                      (idleCount == IDLE_LAST);
  // Writing the wakeup bit as one also clears suspended status
  wire wakeWrite    = wrPower & xWrData[`UCR_POW_WAKE];

  // Flag and status next values; hardware sets beat read clears
  always @* begin
    next_inFlags  = upd(inFlags, inEndpointEvent, rdInF);
    next_outFlags = upd({outFlags, 1'b0}, {outEndpointEvent, 1'b0}, rdOutF);
    // Common flags clear on read, then each event sets its own bit
    next_comFlags = rdComF ? 4'h0 : comFlags;
    if (frameStart) begin
      next_comFlags[`UCR_CF_SOF] = 1'b1;
    end
    if (busResetRise) begin
      next_comFlags[`UCR_CF_RST] = 1'b1;
    end
    if (resumeEvent) begin
      next_comFlags[`UCR_CF_WAKE] = 1'b1;
    end
    if (suspendEnter) begin
      next_comFlags[`UCR_CF_SLEEP] = 1'b1;
    end
    // Suspended status: a clear and an entry together leave it set
    next_suspendMode = suspendMode;
    if (rdComF || wakeWrite || resumeDrive) begin
      next_suspendMode = 1'b0;
    end
    if (suspendEnter) begin
      next_suspendMode = 1'b1;
    end
  end

  // Shared interrupt from enabled flags, evaluated on the new values
  always @* begin
    next_irq = |(next_inFlags & inEnables[5:0]) |
               |(next_outFlags[5:1] & outEnables[5:1]) |
               |(next_comFlags & comEnables);
  end

  // Read mux; unmapped window addresses and reserved bits read zero, except IN and OUT enable bits 7:6
  always @* begin
    next_rdData = 8'h00;
    if (rd) begin
      case (xAddr)
        `UCR_OFS_ADDR: begin
          next_rdData = {addrPending, functionAddress};
        end
        `UCR_OFS_POWER: begin
          next_rdData = {isoHoldEn, 3'b000, busResetActive, resumeDrive,
                         suspendMode, suspendAllow};
        end
        `UCR_OFS_INFLAG: begin
          next_rdData = {2'b00, inFlags};
        end
        `UCR_OFS_OUTFLAG: begin
          next_rdData = {2'b00, outFlags, 1'b0};
        end
        `UCR_OFS_COMFLAG: begin
          next_rdData = {4'h0, comFlags};
        end
        `UCR_OFS_INEN: begin
          next_rdData = inEnables;
        end
        `UCR_OFS_OUTEN: begin
          next_rdData = outEnables & `UCR_OUTEN_MASK;
        end
        `UCR_OFS_COMEN: begin
          next_rdData = {4'h0, comEnables};
        end
        default: begin
          next_rdData = 8'h00;
        end
      endcase
    end
  end

  // Event flags, read data and interrupt line
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      inFlags       <= 6'h00;
      outFlags      <= 5'h00;
      comFlags      <= 4'h0;
      suspendMode   <= 1'b0;
      xRdData       <= 8'h00;
      controllerIrq <= 1'b0;
    end else if (ce) begin
      inFlags       <= next_inFlags;
      outFlags      <= next_outFlags[5:1];
      comFlags      <= next_comFlags;
      suspendMode   <= next_suspendMode;
      xRdData       <= next_rdData;
      controllerIrq <= next_irq;
    end
  end

  // Function address and its pending flag
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      functionAddress <= `UCR_RST_ADDR;
      addrPending     <= 1'b0;
    end else if (ce) begin
      // Bus reset outranks a firmware write in the same cycle
      if (busResetRise) begin
        functionAddress <= 7'h00;
        addrPending     <= 1'b0;
      end else if (wrAddr) begin
        functionAddress <= xWrData[6:0];
        addrPending     <= 1'b1;
      end else if (addrApplied) begin
        addrPending     <= 1'b0;
      end
    end
  end

  // Power control bits written by firmware
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      isoHoldEn    <= 1'b0;
      resumeDrive  <= 1'b0;
      suspendAllow <= 1'b0;
    end else if (ce) begin
      // Read-only bits 6:3 and 1 are not stored here
      if (wrPower) begin
        isoHoldEn    <= xWrData[`UCR_POW_ISOHOLD];
        // Pulse length is firmware's job; no timeout is imposed here
        resumeDrive  <= xWrData[`UCR_POW_WAKE];
        suspendAllow <= xWrData[`UCR_POW_ALLOW];
      end
    end
  end

  // Interrupt enables; bus reset sets all but frame start and suspend
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      inEnables  <= `UCR_RST_INEN;
      outEnables <= `UCR_RST_OUTEN;
      comEnables <= `UCR_RST_COMEN;
    end else if (ce) begin
      if (busResetRise) begin
        inEnables                <= `UCR_RST_INEN;
        outEnables               <= `UCR_RST_OUTEN;
        // Frame start and suspend enables keep their value
        comEnables[`UCR_CF_RST]  <= 1'b1;
        comEnables[`UCR_CF_WAKE] <= 1'b1;
      end else begin
        if (wrInEn) begin
          // Bits 7:6 are stored as written; firmware keeps them zero
          inEnables <= xWrData;
        end
        if (wrOutEn) begin
          outEnables <= xWrData & `UCR_OUTEN_MASK;
        end
        if (wrComEn) begin
          comEnables <= xWrData[3:0];
        end
      end
    end
  end

  // Bus idle timer; one suspend per idle stretch
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      idleCount <= {CNT_W{1'b0}};
      idleSpent <= 1'b0;
    end else if (ce) begin
      // Bus activity or a cleared allow bit restarts the count
      if (!busIdle || !suspendAllow) begin
        idleCount <= {CNT_W{1'b0}};
        idleSpent <= 1'b0;
      end else if (suspendEnter) begin
        // Counter parks after entry so one idle stretch suspends once
        idleCount <= {CNT_W{1'b0}};
        idleSpent <= 1'b1;
      end else if (!idleSpent) begin
        idleCount <= idleCount + 1'b1;
      end
    end
  end

  // Edge history of the bus level inputs
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      // Zero is the quiet level of reset signaling, so no false edge
      busResetSeen <= 1'b0;
      busIdleSeen  <= 1'b0;
    end else if (ce) begin
      busResetSeen <= busResetActive;
      busIdleSeen  <= busIdle;
    end
  end

  // Endpoint state clear pulse for the packet engine on bus reset
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      endpointStateClear <= 1'b0;
    end else if (ce) begin
      endpointStateClear <= busResetRise;
    end
  end

  // Iso hold: zero-length answers from packet load until frame start
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      isoZeroLenHold <= 1'b0;
    end else if (ce) begin
      // A load in the same cycle as a frame start wins
      if (isoHoldEn && inPacketLoaded && inEndpointIsIso) begin
        isoZeroLenHold <= 1'b1;
      end else if (frameStart || !isoHoldEn) begin
        isoZeroLenHold <= 1'b0;
      end
    end
  end

endmodule

// ==== design/ucr_regs.vh ====
`ifndef UCR_REGS_VH
`define UCR_REGS_VH

// Register window in the external data space
`define UCR_WIN_BASE      16'hDE00
`define UCR_WIN_LAST      16'hDE3F

// Register byte addresses
`define UCR_OFS_ADDR      16'hDE00
`define UCR_OFS_POWER     16'hDE01
`define UCR_OFS_INFLAG    16'hDE02
`define UCR_OFS_OUTFLAG   16'hDE04
`define UCR_OFS_COMFLAG   16'hDE06
`define UCR_OFS_INEN      16'hDE07
`define UCR_OFS_OUTEN     16'hDE09
`define UCR_OFS_COMEN     16'hDE0B

// Function address fields
`define UCR_ADDR_PEND_BIT 7

// Power control fields
`define UCR_POW_ISOHOLD   7
`define UCR_POW_BUSRST    3
`define UCR_POW_WAKE      2
`define UCR_POW_SUSP      1
`define UCR_POW_ALLOW     0

// Common event fields
`define UCR_CF_SOF        3
`define UCR_CF_RST        2
`define UCR_CF_WAKE       1
`define UCR_CF_SLEEP      0

// Reset values
`define UCR_RST_ADDR      7'h00
`define UCR_RST_POWER     8'h00
`define UCR_RST_INEN      8'h3F
`define UCR_RST_OUTEN     8'h3E
`define UCR_RST_COMEN     4'h6
`define UCR_OUTEN_MASK    8'hFE

// Timing
`define UCR_SUSP_IDLE_MS  3
`define UCR_CYC_PER_MS    100000
`define UCR_WAKE_MIN_MS   1
`define UCR_WAKE_MAX_MS   15

`endif

// ==== dv/ucr_common_regs_assertions.sv ====
`timescale 1ns/100ps
`include "ucr_regs.vh"
module ucr_common_regs_assertions #(
  parameter integer SUSPEND_IDLE_CYCLES = `UCR_SUSP_IDLE_MS * `UCR_CYC_PER_MS
) (
  input wire        clk,
  input wire        resetn,
  input wire        ce,
  input wire [15:0] xAddr,
  input wire [7:0]  xWrData,
  input wire        xWrEn,
  input wire        xRdEn,
  input wire [7:0]  xRdData,
  input wire        inPacketLoaded,
  input wire        frameStart,
  input wire        busResetActive,
  input wire        busIdle,
  input wire [6:0]  functionAddress,
  input wire        isoZeroLenHold,
  input wire        resumeDrive,
  input wire        suspendMode,
  input wire        endpointStateClear,
  input wire        controllerIrq
);
  // Idle run length, so suspend entry can be timed against it
  reg [31:0] idleRun;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) idleRun <= 32'h0;
    else if (ce) idleRun <= busIdle ? idleRun + 32'h1 : 32'h0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_addr_write: assert property (ce && xWrEn && xAddr == `UCR_OFS_ADDR
    && !busResetActive |=> {1'b0, functionAddress} == ($past(xWrData) & 8'h7F))
    else $error("address write not taken");
  a_iso_clear: assert property (ce && frameStart && !inPacketLoaded
    |=> !isoZeroLenHold) else $error("iso hold kept past frame start");
  a_rst_status: assert property (ce && xRdEn && xAddr == `UCR_OFS_POWER
    |=> xRdData[3] == $past(busResetActive)) else $error("bus reset status wrong");
  a_wake_write: assert property (ce && xWrEn && xAddr == `UCR_OFS_POWER
    |=> resumeDrive == (($past(xWrData) & 8'h04) != 8'h00)) else $error("resume drive wrong");
  a_wake_clears: assert property (ce && !busIdle && resumeDrive
    |=> !suspendMode) else $error("suspend kept during resume");
  a_idle_entry: assert property ($rose(suspendMode)
    |-> idleRun >= SUSPEND_IDLE_CYCLES) else $error("suspend entered early");
  a_reset_clears: assert property (ce && $rose(busResetActive)
    |=> functionAddress == 7'h00 && endpointStateClear) else $error("bus reset not applied");
  a_clear_single: assert property (ce && endpointStateClear
    |=> !endpointStateClear) else $error("endpoint clear pulse too long");
  a_irq_on_reset: assert property (ce && $rose(busResetActive)
    |=> ##[0:1] controllerIrq) else $error("no interrupt on bus reset");
  a_window_only: assert property (ce && xRdEn
    && (xAddr < `UCR_WIN_BASE || xAddr > `UCR_WIN_LAST) |=> xRdData == 8'h00)
    else $error("read outside window answered");
endmodule

bind ucr_common_regs ucr_common_regs_assertions #(
  .SUSPEND_IDLE_CYCLES(SUSPEND_IDLE_CYCLES)) u_chk (.clk(clk), .resetn(resetn), .ce(ce),
  .xAddr(xAddr), .xWrData(xWrData), .xWrEn(xWrEn), .xRdEn(xRdEn), .xRdData(xRdData),
  .inPacketLoaded(inPacketLoaded), .frameStart(frameStart), .busResetActive(busResetActive),
  .busIdle(busIdle), .functionAddress(functionAddress), .isoZeroLenHold(isoZeroLenHold),
  .resumeDrive(resumeDrive), .suspendMode(suspendMode),
  .endpointStateClear(endpointStateClear), .controllerIrq(controllerIrq));

// ==== dv/ucr_common_regs_tb.sv ====
`timescale 1ns/100ps
`include "ucr_regs.vh"
module ucr_common_regs_tb;
  localparam integer IDLE_N = 50;
  logic        clk, resetn, ce, xWrEn, xRdEn, addrApplied, inPacketLoaded, inEndpointIsIso;
  logic        frameStart, busResetActive, busIdle, isoZeroLenHold, resumeDrive, strobe;
  logic        suspendMode, endpointStateClear, controllerIrq;
  logic [15:0] xAddr;
  logic [7:0]  xWrData, xRdData, r, e;
  logic [5:0]  inEndpointEvent;
  logic [5:1]  outEndpointEvent;
  logic [6:0]  functionAddress;
  logic [7:0]  expQ[$];
  int          err_count, total_checks, i;
`define CHK(n, x, a) begin total_checks++; if ((a) !== (x)) begin err_count++; \
  $display("CHECK FAILED %s exp %h got %h", n, x, a); end end

  ucr_common_regs #(.SUSPEND_IDLE_CYCLES(IDLE_N)) u_ucr_common_regs (.clk(clk),
    .resetn(resetn), .ce(ce), .xAddr(xAddr), .xWrData(xWrData), .xWrEn(xWrEn),
    .xRdEn(xRdEn), .xRdData(xRdData), .addrApplied(addrApplied),
    .inPacketLoaded(inPacketLoaded), .inEndpointIsIso(inEndpointIsIso),
    .frameStart(frameStart), .busResetActive(busResetActive), .busIdle(busIdle),
    .inEndpointEvent(inEndpointEvent), .outEndpointEvent(outEndpointEvent),
    .functionAddress(functionAddress), .isoZeroLenHold(isoZeroLenHold),
    .resumeDrive(resumeDrive), .suspendMode(suspendMode),
    .endpointStateClear(endpointStateClear), .controllerIrq(controllerIrq));
  ucr_usb_host u_ucr_usb_host (.clk(clk), .frameStart(frameStart),
    .busResetActive(busResetActive), .busIdle(busIdle));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Read data stands for the cycle after the strobe edge; judge it mid-cycle
  always @(posedge clk) strobe <= xRdEn & ce;
  always @(negedge clk) begin
    if (strobe === 1'b1) begin
      e = expQ.pop_front();
      `CHK("read data", e, xRdData)
    end
  end
  task wr(input [15:0] a, input [7:0] d);
    begin
      @(posedge clk);
      #1 xAddr = a;
      xWrData = d;
      xWrEn = 1'b1;
      @(posedge clk);
      #1 xWrEn = 1'b0;
    end
  endtask
  task rd(input [15:0] a, input [7:0] x);
    begin
      expQ.push_back(x);
      @(posedge clk);
      #1 xAddr = a;
      xRdEn = 1'b1;
      @(posedge clk);
      #1 xRdEn = 1'b0;
    end
  endtask
  // One-cycle pulses from the packet engine
  task ev(input [5:0] ie, input [5:1] oe, input ap, input pl);
    begin
      @(posedge clk);
      #1 inEndpointEvent = ie;
      outEndpointEvent = oe;
      addrApplied = ap;
      inPacketLoaded = pl;
      @(posedge clk);
      #1 inEndpointEvent = 6'h00;
      outEndpointEvent = 5'h00;
      addrApplied = 1'b0;
      inPacketLoaded = 1'b0;
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    finish_test;
  end

  initial begin
    r = $urandom(34);
    ce = 1'b1;
    xWrEn = 1'b0;
    xRdEn = 1'b0;
    addrApplied = 1'b0;
    inPacketLoaded = 1'b0;
    inEndpointIsIso = 1'b0;
    xAddr = 16'h0000;
    xWrData = 8'h00;
    inEndpointEvent = 6'h00;
    outEndpointEvent = 5'h00;
    resetn = 1'b0;
    repeat (12) @(posedge clk);
    #1 resetn = 1'b1;
    rd(`UCR_OFS_ADDR, 8'h00);
    rd(`UCR_OFS_POWER, 8'h00);
    rd(`UCR_OFS_INFLAG, 8'h00);
    rd(`UCR_OFS_OUTFLAG, 8'h00);
    rd(`UCR_OFS_COMFLAG, 8'h00);
    rd(`UCR_OFS_INEN, 8'h3F);
    rd(`UCR_OFS_OUTEN, 8'h3E);
    rd(`UCR_OFS_COMEN, 8'h06);
    rd(16'hDE03, 8'h00);
    rd(16'hDE40, 8'h00);
    $display("reset values done");
    r = $urandom;
    wr(`UCR_OFS_ADDR, r);
    `CHK("address", r[6:0], functionAddress)
    rd(`UCR_OFS_ADDR, {1'b1, r[6:0]});
    ev(6'h00, 5'h00, 1'b1, 1'b0);
    rd(`UCR_OFS_ADDR, {1'b0, r[6:0]});
    r = $urandom & 8'h3F;
    wr(`UCR_OFS_INEN, r);
    rd(`UCR_OFS_INEN, r);
    wr(`UCR_OFS_OUTEN, r);
    rd(`UCR_OFS_OUTEN, r & 8'h3E);
    $display("address and enables done");
    wr(`UCR_OFS_INEN, 8'h3F);
    wr(`UCR_OFS_OUTEN, 8'h3E);
    wr(`UCR_OFS_COMEN, 8'h09);
    // Every endpoint flag sets, raises the line, and clears on read
    for (i = 0; i < 11; i++) begin
      if (i < 6) ev(6'h01 << i, 5'h00, 1'b0, 1'b0);
      else ev(6'h00, 5'h01 << (i - 6), 1'b0, 1'b0);
      `CHK("irq set", 1'b1, controllerIrq)
      if (i < 6) rd(`UCR_OFS_INFLAG, 8'h01 << i);
      else rd(`UCR_OFS_OUTFLAG, 8'h02 << (i - 6));
      `CHK("irq clear", 1'b0, controllerIrq)
    end
    wr(`UCR_OFS_INEN, 8'h00);
    ev(6'h20, 5'h00, 1'b0, 1'b0);
    `CHK("irq masked", 1'b0, controllerIrq)
    rd(`UCR_OFS_INFLAG, 8'h20);
    // Frame start on the very cycle of the clearing read is kept
    fork
      u_ucr_usb_host.sof();
      rd(`UCR_OFS_COMFLAG, 8'h00);
    join
    `CHK("irq sof", 1'b1, controllerIrq)
    rd(`UCR_OFS_COMFLAG, 8'h08);
    $display("event flags done");
    wr(`UCR_OFS_POWER, 8'h80);
    ev(6'h00, 5'h00, 1'b0, 1'b1);
    `CHK("iso hold", 1'b0, isoZeroLenHold)
    inEndpointIsIso = 1'b1;
    ev(6'h00, 5'h00, 1'b0, 1'b1);
    `CHK("iso hold", 1'b1, isoZeroLenHold)
    u_ucr_usb_host.sof();
    `CHK("iso hold", 1'b0, isoZeroLenHold)
    rd(`UCR_OFS_COMFLAG, 8'h08);
    wr(`UCR_OFS_POWER, 8'h00);
    $display("iso hold done");
    // No suspend without the allow bit, then entry on the exact idle count
    u_ucr_usb_host.setIdle(1'b1);
    repeat (IDLE_N + 4) @(posedge clk);
    #1 `CHK("suspend", 1'b0, suspendMode)
    u_ucr_usb_host.setIdle(1'b0);
    wr(`UCR_OFS_POWER, 8'h01);
    u_ucr_usb_host.setIdle(1'b1);
    repeat (IDLE_N - 1) @(posedge clk);
    #1 `CHK("suspend", 1'b0, suspendMode)
    @(posedge clk);
    #1 `CHK("suspend", 1'b1, suspendMode)
    rd(`UCR_OFS_POWER, 8'h03);
    u_ucr_usb_host.setIdle(1'b0);
    rd(`UCR_OFS_COMFLAG, 8'h03);
    rd(`UCR_OFS_POWER, 8'h01);
    u_ucr_usb_host.setIdle(1'b1);
    repeat (IDLE_N + 2) @(posedge clk);
    wr(`UCR_OFS_POWER, 8'h05);
    `CHK("resume", 1'b1, resumeDrive)
    `CHK("suspend", 1'b0, suspendMode)
    u_ucr_usb_host.setIdle(1'b0);
    repeat (20) @(posedge clk);
    wr(`UCR_OFS_POWER, 8'h00);
    rd(`UCR_OFS_COMFLAG, 8'h01);
    $display("suspend and resume done");
    wr(`UCR_OFS_ADDR, 8'h15);
    wr(`UCR_OFS_COMEN, 8'h00);
    u_ucr_usb_host.setReset(1'b1);
    @(posedge clk);
    #1 `CHK("ep clear", 1'b1, endpointStateClear)
    rd(`UCR_OFS_POWER, 8'h08);
    `CHK("address", 7'h00, functionAddress)
    `CHK("irq reset", 1'b1, controllerIrq)
    u_ucr_usb_host.setReset(1'b0);
    rd(`UCR_OFS_ADDR, 8'h00);
    rd(`UCR_OFS_INEN, 8'h3F);
    rd(`UCR_OFS_OUTEN, 8'h3E);
    rd(`UCR_OFS_COMEN, 8'h06);
    rd(`UCR_OFS_COMFLAG, 8'h04);
    $display("bus reset done");
    // Clock enable low: a write and a burst of events leave no trace
    ce = 1'b0;
    r = $urandom;
    wr(`UCR_OFS_ADDR, r);
    ev(6'h3F, 5'h1F, 1'b1, 1'b1);
    `CHK("frozen address", 7'h00, functionAddress)
    `CHK("frozen irq", 1'b0, controllerIrq)
    ce = 1'b1;
    rd(`UCR_OFS_ADDR, 8'h00);
    rd(`UCR_OFS_INFLAG, 8'h00);
    rd(`UCR_OFS_OUTFLAG, 8'h00);
    $display("clock enable done");
    repeat (2) @(posedge clk);
    finish_test;
  end
endmodule

// ==== dv/ucr_usb_host.sv ====
`timescale 1ns/100ps
// Bus side of the cable: frame starts, reset signaling and idle
module ucr_usb_host (
  input  wire clk,
  output reg  frameStart,
  output reg  busResetActive,
  output reg  busIdle
);
  // Busy bus, no reset, until told otherwise
  initial begin
    frameStart = 1'b0;
    busResetActive = 1'b0;
    busIdle = 1'b0;
  end
  // Frame start token, one clock wide
  task sof;
    begin
      @(posedge clk);
      #1 frameStart = 1'b1;
      @(posedge clk);
      #1 frameStart = 1'b0;
    end
  endtask
  // Levels move just after an edge and hold until moved again
  task setIdle(input v);
    begin
      @(posedge clk);
      #1 busIdle = v;
    end
  endtask
  task setReset(input v);
    begin
      @(posedge clk);
      #1 busResetActive = v;
    end
  endtask
endmodule
